// *** rtl/ltme_top.sv ***
// Purpose: Limit timer mode engine: 8-bit period timer with gate, limit and one-shot modes
// Assumes: Timer clock is aclk qualified by clk_en; software on AXI4-Lite
// Notes:   The external input is a pin and is filtered by three flops
//
// Overview of operation
// - Mode 00000 counts while run-enable set
// - Free-running: after period match reload zero
// - Gate modes also hold on input level
// - Edge limit modes clear count on edge
// - After edge clear, counting restarts two clocks later
// - Level limit modes hold count cleared
// - Level limit ignores input while run clear
// - Level clear at match or after two clocks
// - Level resume after match or two clocks
// - Software one-shot clears count and run-enable
// - Software one-shot pause resumes from held value
// - New one-shot cycle needs run-enable set again
// - Edge one-shot starts on edge after enable
// - Edge one-shot pause needs a new edge
// - Limit one-shot: first edge starts, later clear
// - Limit one-shot resumes two clocks after clearing
// - Limit one-shot match clears run, ignores edges
// - Run sets synchronised two clocks, clears at once; input changes four
// - Pulse stays high through held level reset
// - One-shot match stops count at zero
// - Period any value zero to 255
`timescale 1ns/1ps
module ltme_top #(
  parameter int CNT_W = 8 // Count and period width
) (
  input  logic             aclk,           // Bus and timer clock
  input  logic             aresetn,        // Synchronous reset, low active
  input  logic             clk_en,         // Timer clock qualifier, freezes all
  input  logic             ext_reset_line, // External reset input pin
  input  logic [4:0]       s_axi_awaddr,
  input  logic             s_axi_awvalid,
  output logic             s_axi_awready,
  input  logic [31:0]      s_axi_wdata,
  input  logic [3:0]       s_axi_wstrb,
  input  logic             s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  logic             s_axi_bready,
  input  logic [4:0]       s_axi_araddr,
  input  logic             s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  logic             s_axi_rready,
  output logic [CNT_W-1:0] count_value,    // Live count
  output logic             postscaled_match_out, // One-tick pulse at period match
  output logic             pulse_out       // Pulse drive for a compare unit
);

  // Software-visible state
  logic             run_en_q;     // Run-enable bit
  logic [4:0]       mode_q;       // Mode code
  logic [CNT_W-1:0] period_value; // Period register
  logic [CNT_W-1:0] pwidth_q;     // Pulse-width compare
  logic [CNT_W-1:0] count_q;      // Counter
  logic             pulse_q;      // Pulse drive level
  logic             match_q;      // Registered match pulse

  localparam int LTME_SYNC_N = ltme_pkg::LTME_RUN_SYNC_CLKS;

  // Engine state
  logic [LTME_SYNC_N-1:0] run_pipe_q;  // Run-enable sync pipeline
  logic [2:0]            ext_ff_q;     // External input synchroniser
  logic                  ext_q;        // Filtered external level
  logic                  ext_prev_q;   // Previous filtered level
  logic                  armed_q;      // Edge start seen since enable
  logic [1:0]            dly_q;        // Restart delay remaining
  logic [1:0]            age_q;        // Ticks the reset level has held
  logic                  hw_clr;       // Engine clears run-enable this tick
  logic                  counting;     // Count advances this tick

  // Bus handshake state
  logic        aw_held_q;
  logic [4:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;        // Both halves of a write present

  // Pin filter: a change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_ff_q <= 3'h0;
      ext_q    <= 1'b0;
    end else if (clk_en) begin
      ext_ff_q <= {ext_ff_q[1:0], ext_reset_line};
      if (ext_ff_q[1] == ext_ff_q[2]) begin
        ext_q <= ext_ff_q[2];
      end
    end
  end

  // Previous level for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_q <= 1'b0;
    end else if (clk_en) begin
      ext_prev_q <= ext_q;
    end
  end

  // Run-enable reaches the engine two ticks after a set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_pipe_q <= '0;
    end else if (clk_en) begin
      run_pipe_q <= {run_pipe_q[LTME_SYNC_N-2:0], run_en_q};
    end
  end

  // A clear acts at once so a stopped one-shot never overruns
  logic run_s;
  logic rise_e;
  logic fall_e;
  logic match;
  logic rst_lvl;
  assign run_s   = run_pipe_q[LTME_SYNC_N-1] & run_en_q;
  assign rise_e  = ext_q & ~ext_prev_q;
  assign fall_e  = ~ext_q & ext_prev_q;
  assign match   = (count_q == period_value);
  assign rst_lvl = (mode_q == ltme_pkg::LTME_M_LVL_LO) ? ~ext_q : ext_q;

  // Mode decode: start edge, clear edge, gate level
  logic gate_ok;
  logic start_edge;
  logic clear_edge;
  always_comb begin
    gate_ok    = 1'b1;
    start_edge = 1'b0;
    clear_edge = 1'b0;
    case (mode_q)
      ltme_pkg::LTME_M_GATE_HI:   gate_ok = ~ext_q;
      ltme_pkg::LTME_M_GATE_LO:   gate_ok = ext_q;
      ltme_pkg::LTME_M_EDGE_ANY:  clear_edge = rise_e | fall_e;
      ltme_pkg::LTME_M_EDGE_RISE: clear_edge = rise_e;
      ltme_pkg::LTME_M_EDGE_FALL: clear_edge = fall_e;
      ltme_pkg::LTME_M_OS_RISE:   start_edge = rise_e;
      ltme_pkg::LTME_M_OS_FALL:   start_edge = fall_e;
      ltme_pkg::LTME_M_OS_ANY:    start_edge = rise_e | fall_e;
      ltme_pkg::LTME_M_OSL_RISE: begin
        start_edge = rise_e;
        clear_edge = rise_e;
      end
      ltme_pkg::LTME_M_OSL_FALL: begin
        start_edge = fall_e;
        clear_edge = fall_e;
      end
      default: gate_ok = 1'b1;
    endcase
  end

  // Engine: one decision per timer clock
  logic [CNT_W-1:0] count_d;
  logic             armed_d;
  logic [1:0]       dly_d;
  logic [1:0]       age_d;
  logic             restart; // Count restarts from zero, pulse goes high
  always_comb begin
    count_d  = count_q;
    armed_d  = armed_q;
    dly_d    = (dly_q != 2'h0) ? dly_q - 2'h1 : 2'h0;
    age_d    = age_q;
    hw_clr   = 1'b0;
    counting = 1'b0;
    restart  = 1'b0;
    case (mode_q)
      ltme_pkg::LTME_M_SW_GATE, ltme_pkg::LTME_M_GATE_HI, ltme_pkg::LTME_M_GATE_LO: begin
        if (run_s && gate_ok) begin
          counting = 1'b1;
          count_d  = match ? '0 : count_q + 1'b1;
          restart  = match;
        end
      end
      ltme_pkg::LTME_M_EDGE_ANY, ltme_pkg::LTME_M_EDGE_RISE, ltme_pkg::LTME_M_EDGE_FALL: begin
        if (run_s) begin
          if (clear_edge && !match) begin
            count_d = '0;
            dly_d   = ltme_pkg::LTME_RESTART_CLKS;
          end else if (dly_q == 2'h0) begin
            counting = 1'b1;
            count_d  = match ? '0 : count_q + 1'b1;
            restart  = match;
          end else if (dly_q == 2'h1) begin
            restart = 1'b1;
          end
        end
      end
      ltme_pkg::LTME_M_LVL_LO, ltme_pkg::LTME_M_LVL_HI: begin
        if (run_s) begin
          if (rst_lvl) begin
            age_d = (age_q == ltme_pkg::LTME_LEVEL_CLKS) ? age_q : age_q + 2'h1;
            dly_d = ltme_pkg::LTME_RESTART_CLKS;
            if (age_d == ltme_pkg::LTME_LEVEL_CLKS) begin
              count_d = '0;
            end
          end else begin
            age_d = 2'h0;
            if (dly_q == 2'h0) begin
              counting = 1'b1;
              count_d  = match ? '0 : count_q + 1'b1;
              restart  = match;
            end else if (dly_q == 2'h1) begin
              restart = 1'b1;
            end
          end
        end
      end
      ltme_pkg::LTME_M_OS_SW: begin
        if (run_s) begin
          counting = 1'b1;
          count_d  = match ? '0 : count_q + 1'b1;
          hw_clr   = match;
        end
      end
      ltme_pkg::LTME_M_OS_RISE, ltme_pkg::LTME_M_OS_FALL, ltme_pkg::LTME_M_OS_ANY: begin
        if (!run_s) begin
          armed_d = 1'b0;
        end else if (!armed_q) begin
          armed_d = start_edge;
        end else begin
          counting = 1'b1;
          count_d  = match ? '0 : count_q + 1'b1;
          hw_clr   = match;
          armed_d  = ~match;
        end
      end
      ltme_pkg::LTME_M_OSL_RISE, ltme_pkg::LTME_M_OSL_FALL: begin
        if (!run_s) begin
          armed_d = 1'b0;
        end else if (!armed_q) begin
          armed_d = start_edge;
        end else if (clear_edge && !match) begin
          count_d = '0;
          dly_d   = ltme_pkg::LTME_RESTART_CLKS;
        end else if (dly_q == 2'h0) begin
          counting = 1'b1;
          count_d  = match ? '0 : count_q + 1'b1;
          hw_clr   = match;
          armed_d  = ~match;
        end else if (dly_q == 2'h1) begin
          restart = 1'b1;
        end
      end
      default: begin
        count_d = count_q;
        dly_d   = 2'h0;
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
      dly_q   <= 2'h0;
      age_q   <= 2'h0;
      match_q <= 1'b0;
    end else if (clk_en) begin
      armed_q <= armed_d;
      dly_q   <= dly_d;
      age_q   <= age_d;
      match_q <= counting & match;
    end
  end

  // Count: a software write loads it, else the engine steps it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= ltme_pkg::LTME_RST_COUNT;
    end else if (clk_en) begin
      if (wr_go && aw_addr_q == ltme_pkg::LTME_OFS_COUNT && w_strb_q[0]) begin
        count_q <= w_data_q[CNT_W-1:0];
      end else begin
        count_q <= count_d;
      end
    end
  end

  // Pulse: set on restart or start, cleared when the count reaches compare
  // A held count cannot reach compare, so a held reset stretches the pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_q <= 1'b0;
    end else if (clk_en) begin
      if (counting && count_d == pwidth_q) begin
        pulse_q <= 1'b0;
      end else if (restart || (!armed_q && armed_d) || (counting && count_q == '0 && !pulse_q
                   && mode_q == ltme_pkg::LTME_M_OS_SW)) begin
        pulse_q <= 1'b1;
      end
    end
  end

  // Control; a software set wins over a hardware clear in one tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_en_q <= 1'b0;
      mode_q   <= ltme_pkg::LTME_RST_MODE;
    end else if (clk_en) begin
      if (wr_go && aw_addr_q == ltme_pkg::LTME_OFS_CTRL && w_strb_q[0]) begin
        run_en_q <= w_data_q[ltme_pkg::LTME_CTRL_RUN_BIT];
        mode_q   <= w_data_q[ltme_pkg::LTME_CTRL_MODE_HI:ltme_pkg::LTME_CTRL_MODE_LO];
      end else if (hw_clr) begin
        run_en_q <= 1'b0;
      end
    end
  end

  // Period and compare registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_value <= ltme_pkg::LTME_RST_PERIOD;
      pwidth_q     <= ltme_pkg::LTME_RST_PWIDTH;
    end else if (clk_en && wr_go && w_strb_q[0]) begin
      if (aw_addr_q == ltme_pkg::LTME_OFS_PERIOD) begin
        period_value <= w_data_q[CNT_W-1:0];
      end
      if (aw_addr_q == ltme_pkg::LTME_OFS_PWIDTH) begin
        pwidth_q <= w_data_q[CNT_W-1:0];
      end
    end
  end

  // Write channel capture: address and data taken in either order
  assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 5'h00;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[4:2], 2'h0};
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Ready flags: low while a half is held, so one write is under way at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= ~(aw_held_q | (s_axi_awvalid & s_axi_awready)) & ~s_axi_bvalid;
      s_axi_wready  <= ~(w_held_q | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
    end
  end

  // Write response
  logic wr_mapped;
  assign wr_mapped = (aw_addr_q == ltme_pkg::LTME_OFS_CTRL) ||
                     (aw_addr_q == ltme_pkg::LTME_OFS_PERIOD) ||
                     (aw_addr_q == ltme_pkg::LTME_OFS_COUNT) ||
                     (aw_addr_q == ltme_pkg::LTME_OFS_PWIDTH);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ltme_pkg::LTME_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? ltme_pkg::LTME_RESP_OKAY : ltme_pkg::LTME_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data mux
  logic [31:0] rd_d;
  logic        rd_ok;
  always_comb begin
    rd_d  = 32'h0;
    rd_ok = 1'b1;
    case ({s_axi_araddr[4:2], 2'h0})
      ltme_pkg::LTME_OFS_CTRL: begin
        rd_d[ltme_pkg::LTME_CTRL_RUN_BIT] = run_en_q;
        rd_d[ltme_pkg::LTME_CTRL_MODE_HI:ltme_pkg::LTME_CTRL_MODE_LO] = mode_q;
      end
      ltme_pkg::LTME_OFS_PERIOD: rd_d[CNT_W-1:0] = period_value;
      ltme_pkg::LTME_OFS_COUNT:  rd_d[CNT_W-1:0] = count_q;
      ltme_pkg::LTME_OFS_PWIDTH: rd_d[CNT_W-1:0] = pwidth_q;
      ltme_pkg::LTME_OFS_STATUS: begin
        rd_d[ltme_pkg::LTME_STAT_COUNTING] = counting;
        rd_d[ltme_pkg::LTME_STAT_ARMED]    = armed_q;
        rd_d[ltme_pkg::LTME_STAT_EXT]      = ext_q;
        rd_d[ltme_pkg::LTME_STAT_PULSE]    = pulse_q;
        rd_d[ltme_pkg::LTME_STAT_RUN_SYNC] = run_s;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel: one read at a time, data one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= ltme_pkg::LTME_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_d;
        s_axi_rresp   <= rd_ok ? ltme_pkg::LTME_RESP_OKAY : ltme_pkg::LTME_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Timer outputs, all from flops
  assign count_value          = count_q;
  assign postscaled_match_out = match_q;
  assign pulse_out            = pulse_q;

endmodule

// *** rtl/ltme_pkg.sv ***
// Purpose: Shared constants and types of the limit timer mode engine
// Assumes: AXI4-Lite register access with 32-bit data, byte addresses
// Notes:   Each number lives here once; the design refers to it by name
package ltme_pkg;

  // Register byte offsets
  localparam logic [4:0] LTME_OFS_CTRL   = 5'h00; // Run-enable and mode
  localparam logic [4:0] LTME_OFS_PERIOD = 5'h04; // Period value
  localparam logic [4:0] LTME_OFS_COUNT  = 5'h08; // Count value, read and load
  localparam logic [4:0] LTME_OFS_STATUS = 5'h0C; // Live engine state
  localparam logic [4:0] LTME_OFS_PWIDTH = 5'h10; // Pulse-width compare

  // Control register fields
  localparam int LTME_CTRL_RUN_BIT = 7;  // Run-enable bit position
  localparam int LTME_CTRL_MODE_LO = 0;  // Mode field low bit
  localparam int LTME_CTRL_MODE_HI = 4;  // Mode field high bit

  // Status register fields
  localparam int LTME_STAT_COUNTING = 0; // Count advanced this tick
  localparam int LTME_STAT_ARMED    = 1; // Edge start has been seen
  localparam int LTME_STAT_EXT      = 2; // Filtered external level
  localparam int LTME_STAT_PULSE    = 3; // Pulse output level
  localparam int LTME_STAT_RUN_SYNC = 4; // Run-enable as seen by the engine

  // Values after reset
  localparam logic [7:0] LTME_RST_COUNT  = 8'h00;
  localparam logic [7:0] LTME_RST_PERIOD = 8'hFF;
  localparam logic [7:0] LTME_RST_PWIDTH = 8'h00;
  localparam logic [4:0] LTME_RST_MODE   = 5'h00;

  // Timing: restart delay after a hardware clear, in timer clocks
  localparam logic [1:0] LTME_RESTART_CLKS = 2'h2;
  // Timing: a held reset level clears the count after this many timer clocks
  localparam logic [1:0] LTME_LEVEL_CLKS   = 2'h2;
  // Timing: run-enable sync stages, in timer clocks
  localparam int         LTME_RUN_SYNC_CLKS = 2;

  // AXI responses
  localparam logic [1:0] LTME_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LTME_RESP_SLVERR = 2'h2;

  // Operating modes, 5-bit code
  typedef enum logic [4:0] {
    LTME_M_SW_GATE   = 5'b00000, // Software gate
    LTME_M_GATE_HI   = 5'b00001, // Held while input high
    LTME_M_GATE_LO   = 5'b00010, // Held while input low
    LTME_M_EDGE_ANY  = 5'b00011, // Clear on either edge
    LTME_M_EDGE_RISE = 5'b00100, // Clear on rising edge
    LTME_M_EDGE_FALL = 5'b00101, // Clear on falling edge
    LTME_M_LVL_LO    = 5'b00110, // Held clear while low
    LTME_M_LVL_HI    = 5'b00111, // Held clear while high
    LTME_M_OS_SW     = 5'b01000, // Software start one-shot
    LTME_M_OS_RISE   = 5'b01001, // Rising edge start one-shot
    LTME_M_OS_FALL   = 5'b01010, // Falling edge start one-shot
    LTME_M_OS_ANY    = 5'b01011, // Any edge start one-shot
    LTME_M_OSL_RISE  = 5'b01100, // Rising start and clear one-shot
    LTME_M_OSL_FALL  = 5'b01101  // Falling start and clear one-shot
  } ltme_mode_t;

endpackage

// *** testbench/ltme_chk.sv ***
// Purpose: Port checker for the limit timer mode engine
// Assumes: Address and data of a write are taken at one edge
// Notes:   Mode, run and period are shadowed from bus writes
`timescale 1ns/1ps
module ltme_chk #(
  parameter int CNT_W = 8 // Count width
) (
  input logic             aclk,
  input logic             aresetn,
  input logic             clk_en,
  input logic             ext_reset_line,
  input logic [4:0]       s_axi_awaddr,
  input logic             s_axi_awvalid,
  input logic             s_axi_awready,
  input logic [31:0]      s_axi_wdata,
  input logic             s_axi_wvalid,
  input logic             s_axi_wready,
  input logic [CNT_W-1:0] count_value,
  input logic             postscaled_match_out
);
  logic [4:0]       mode_q; // Shadow of the mode field
  logic             run_q;  // Run as written; hardware clears unseen
  logic [CNT_W-1:0] per_q;  // Shadow of the period
  logic             wr_go;  // Both write halves taken at this edge
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Snoop writes; run_q is trusted only in modes without a hardware stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= 5'h00;
      run_q  <= 1'b0;
      per_q  <= '1;
    end else if (wr_go && s_axi_awaddr == ltme_pkg::LTME_OFS_CTRL) begin
      mode_q <= s_axi_wdata[4:0];
      run_q  <= s_axi_wdata[ltme_pkg::LTME_CTRL_RUN_BIT];
    end else if (wr_go && s_axi_awaddr == ltme_pkg::LTME_OFS_PERIOD) begin
      per_q <= s_axi_wdata[CNT_W-1:0];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pin held long enough to pass the input filter
  sequence s_ext_high;
    (ext_reset_line && clk_en)[*4];
  endsequence
  a_reset_clear:
  assert property (disable iff (1'b0) !aresetn && clk_en |=> count_value == '0)
    else $error("count not cleared by reset");
  a_count_step:
  assert property ($changed(count_value) |-> count_value == '0 ||
    count_value == $past(count_value) + 1'b1) else $error("count jumped");
  a_match_zero:
  assert property (postscaled_match_out |-> count_value == '0) else $error("match off zero");
  a_wrap_period:
  assert property (mode_q == 5'h00 && count_value == '0 && $past(count_value) != '0
    |-> $past(count_value) == per_q) else $error("wrap not at period");
  a_gate_hold:
  assert property ((mode_q == 5'h01 && ext_reset_line && clk_en)[*6] |=> $stable(count_value))
    else $error("gate did not hold");
  a_edge_clear:
  assert property (mode_q == 5'h04 && run_q && $rose(ext_reset_line) ##1 s_ext_high
    |-> ##[0:3] count_value == '0) else $error("edge did not clear");
  a_level_clear:
  assert property ((mode_q == 5'h07 && run_q && ext_reset_line && clk_en)[*8]
    |-> count_value == '0) else $error("level did not clear");
  a_level_ignore:
  assert property ((mode_q == 5'h07 && !run_q && clk_en)[*3] |=> $stable(count_value))
    else $error("input acted while stopped");
  a_oneshot_stop:
  assert property (mode_q inside {[5'h08:5'h0D]} && postscaled_match_out ##1
    (!s_axi_awvalid && clk_en)[*4] |-> count_value == '0) else $error("shot did not stop");
endmodule
bind ltme_top ltme_chk #(.CNT_W(CNT_W)) u_ltme_chk (.*);

// *** testbench/ltme_ers_src.sv ***
// Purpose: Model of the selected external reset source
// Assumes: The bench asks for a level; the pin trails it
// Notes:   LAG of zero answers at once
`timescale 1ns/1ps
module ltme_ers_src #(
  parameter int LAG = 1 // Cycles from request to pin
) (
  input  wire logic aclk,
  input  wire logic level_req,
  output logic      ext_reset_line
);
  logic [7:0] hist_q = 8'h00; // Recent requests, newest in bit 0
  // Push-pull source: the pin always shows a driven level
  always @(posedge aclk) hist_q <= {hist_q[6:0], level_req};
  assign ext_reset_line = (LAG == 0) ? level_req : hist_q[(LAG > 0) ? LAG - 1 : 0];
endmodule

// *** testbench/test_limit_timer_mode_engine.sv ***
// Purpose: Self-checking bench for the limit timer mode engine
// Assumes: Mode and period change only while the timer is stopped
// Notes:   Outputs sampled at the falling edge, drives follow the rising edge
`timescale 1ns/1ps
module test_limit_timer_mode_engine;
  localparam logic [4:0] CTL = ltme_pkg::LTME_OFS_CTRL;
  localparam logic [4:0] PER = ltme_pkg::LTME_OFS_PERIOD;
  localparam logic [1:0] OK  = ltme_pkg::LTME_RESP_OKAY;
  localparam logic [1:0] ERR = ltme_pkg::LTME_RESP_SLVERR;
  logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, lvl = 1'b0, ers;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [1:0]  bresp, rresp;
  logic [7:0]  cnt;
  int          fail_count = 0, num_checks = 0;
  always #25 aclk = ~aclk;
  ltme_top u_ltme_top (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .ext_reset_line(ers),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .count_value(cnt), .postscaled_match_out(), .pulse_out());
  ltme_ers_src #(.LAG(1)) u_ltme_ers_src (.aclk(aclk), .level_req(lvl), .ext_reset_line(ers));
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (e !== s) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // A wait that ran out ends the run
  task automatic guard(input logic ok);
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED wait expected done seen timeout");
      test_done();
    end
  endtask
  // One bus transfer; sampled mid-cycle, released after the taking edge
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [1:0] er, output logic [31:0] rq);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    tb = 1'b0;
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
    for (n = 0; n < 60 && !tb; n++) begin
      @(negedge aclk);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      tb = (bready && bvalid) || (rready && rvalid);
      r = w ? bresp : rresp;
      rq = rdata;
      @(posedge aclk);
      if (ta) {awvalid, arvalid} <= 2'b00;
      if (tw) wvalid <= 1'b0;
      if (tb) {bready, rready} <= 2'b00;
    end
    guard(tb);
    check("bus response", 32'(er), 32'(r));
    @(posedge aclk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, OK, q);
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, OK, q);
    check(nm, e, q);
  endtask
  function automatic logic [31:0] ctl(input logic run, input logic [4:0] m);
    return {24'h0, run, 2'h0, m};
  endfunction
  task automatic wait_cnt(input logic [7:0] v);
    int n;
    @(negedge aclk);
    for (n = 0; n < 600 && cnt !== v; n++) @(negedge aclk);
    guard(n < 600);
    @(posedge aclk);
  endtask
  task automatic expect_cnt(input string nm, input logic [7:0] v);
    @(negedge aclk);
    check(nm, 32'(v), 32'(cnt));
    @(posedge aclk);
  endtask
  // Count must move by exactly adv over six ticks
  task automatic run_check(input string nm, input logic [7:0] adv);
    logic [7:0] c;
    @(negedge aclk);
    c = cnt;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    check(nm, 32'(8'(c + adv)), 32'(cnt));
    @(posedge aclk);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd("period reset", PER, 32'hFF);
    rd("ctrl reset", CTL, 32'h0);
    xfer(1'b1, 5'h14, 32'h1, ERR, q);
    xfer(1'b0, 5'h14, 32'h0, ERR, q);
    check("unmapped data", 32'h0, q);
    wr(PER, 32'h5);
    wr(CTL, ctl(1'b1, 5'h00));
    wait_cnt(8'h05);
    expect_cnt("wrap", 8'h00);
    expect_cnt("count on", 8'h01);
    clk_en <= 1'b0;
    run_check("frozen", 8'h00);
    clk_en <= 1'b1;
    wr(CTL, ctl(1'b0, 5'h00));
    run_check("stopped", 8'h00);
    wr(PER, 32'hFF);
    // Gate modes: idle level counts, the other level holds
    for (int i = 1; i <= 2; i++) begin
      lvl <= (i == 2);
      wr(CTL, ctl(1'b0, 5'(i)));
      wr(CTL, ctl(1'b1, 5'(i)));
      repeat (6) @(posedge aclk);
      run_check("gate open", 8'h06);
      lvl <= (i == 1);
      repeat (6) @(posedge aclk);
      run_check("gate shut", 8'h00);
    end
    // Edge clear modes: clear, then two held ticks, then count
    for (int i = 3; i <= 5; i++) begin
      lvl <= (i == 5);
      wr(CTL, ctl(1'b0, 5'(i)));
      wr(CTL, ctl(1'b1, 5'(i)));
      repeat (20) @(posedge aclk);
      lvl <= (i != 5);
      wait_cnt(8'h00);
      expect_cnt("restart hold", 8'h00);
      expect_cnt("restart hold", 8'h00);
      expect_cnt("restart count", 8'h01);
    end
    lvl <= 1'b0;
    wr(CTL, ctl(1'b0, 5'h07));
    wr(CTL, ctl(1'b1, 5'h07));
    repeat (10) @(posedge aclk);
    wr(CTL, ctl(1'b0, 5'h07));
    lvl <= 1'b1;
    repeat (6) @(posedge aclk);
    run_check("level ignored", 8'h00);
    wr(CTL, ctl(1'b1, 5'h07));
    repeat (10) @(posedge aclk);
    expect_cnt("level clear", 8'h00);
    run_check("level hold", 8'h00);
    lvl <= 1'b0;
    repeat (8) @(posedge aclk);
    run_check("level resume", 8'h06);
    wr(CTL, ctl(1'b0, 5'h08));
    wr(ltme_pkg::LTME_OFS_COUNT, 32'h0);
    wr(PER, 32'h1F);
    wr(CTL, ctl(1'b1, 5'h08));
    wait_cnt(8'h04);
    wr(CTL, ctl(1'b0, 5'h08));
    run_check("paused", 8'h00);
    wr(CTL, ctl(1'b1, 5'h08));
    wait_cnt(8'h1F);
    expect_cnt("shot zero", 8'h00);
    run_check("shot stopped", 8'h00);
    rd("run cleared", CTL, ctl(1'b0, 5'h08));
    wr(CTL, ctl(1'b1, 5'h09));
    run_check("await edge", 8'h00);
    lvl <= 1'b1;
    wait_cnt(8'h1F);
    expect_cnt("edge shot zero", 8'h00);
    rd("edge run cleared", CTL, ctl(1'b0, 5'h09));
    wr(CTL, ctl(1'b1, 5'h1F));
    run_check("unlisted", 8'h00);
    test_done();
  end
endmodule
